// [bench/serial_peer.sv]
// Serial peer: sends frames on rxd, samples frames from txd mid-bit.
// Assumes the caller gives the bit period in core clock cycles.
`timescale 1ns/1ps
`default_nettype none
module serial_peer (
	input  wire logic ref_clk,
	input  wire logic txd,
	output var logic  rxd,
	output var logic  cts_n,
	output var logic  dsr_n,
	output var logic  dcd_n,
	output var logic  ri_n
);
	initial
	begin
		rxd = 1'b1;
		cts_n = 1'b1;
		dsr_n = 1'b1;
		dcd_n = 1'b1;
		ri_n = 1'b1;
	end

	task automatic send(input logic [7:0] b, input int div);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++)
		begin
			rxd <= f[i];
			repeat (div) @(posedge ref_clk);
		end
	endtask

	task automatic modem(input logic [3:0] m);
		@(posedge ref_clk);
		{ri_n, dcd_n, dsr_n, cts_n} <= m;
	endtask

	// Returns the ten bit slots that follow the start bit.
	task automatic get(output logic [9:0] v, input int div);
		while (txd)
			@(posedge ref_clk);
		repeat (div / 2) @(posedge ref_clk);
		for (int i = 0; i < 10; i++)
		begin
			repeat (div) @(posedge ref_clk);
			v[i] = txd;
		end
	endtask
endmodule // serial_peer
`default_nettype wire

// [bench/usb_serial_bridge_uart_monitor.sv]
// Protocol checker for the bridge core: sleep indicators and AXI4-Lite.
// Assumes one clock domain and the asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module usb_serial_bridge_uart_monitor (
	input wire logic        ref_clk,
	input wire logic        rst_n,
	input wire logic        usb_suspend,
	input wire logic        usb_resume,
	input wire logic        usb_bus_reset,
	input wire logic        usb_configured,
	input wire logic        sleep_ind,
	input wire logic        sleep_ind_n,
	input wire logic        sleep_ind_oe,
	input wire logic [7:0]  s_axi_awaddr,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [7:0]  s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready
);
	logic cfg;

	// Enumeration done is sticky until a device reset, not a bus reset.
	always_ff @(posedge ref_clk or negedge rst_n)
		if (!rst_n)
			cfg <= 1'b0;
		else if (usb_configured)
			cfg <= 1'b1;

	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	a_release_asleep:
	assert property ($rose(rst_n) |=> sleep_ind_oe && sleep_ind && !sleep_ind_n)
		else $error("indicators wrong after reset release");
	a_ind_opposite:
	assert property (sleep_ind_oe |-> sleep_ind != sleep_ind_n)
		else $error("indicators not complementary");
	a_suspend_sleeps:
	assert property (usb_suspend && !usb_resume && !usb_bus_reset
		|=> ##1 sleep_ind && !sleep_ind_n)
		else $error("suspend did not assert indicators");
	a_wake_clears:
	assert property ((usb_resume || usb_bus_reset) && cfg ##1 !usb_suspend
		|=> !sleep_ind && sleep_ind_n)
		else $error("wake did not clear indicators");
	a_unconf_asleep:
	assert property (!cfg && sleep_ind_oe |-> sleep_ind && !sleep_ind_n)
		else $error("indicators cleared before configuration");
	a_write_answer:
	assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid
		&& !s_axi_awready |=> s_axi_awready && s_axi_wready && s_axi_bvalid
		&& s_axi_bresp == (($past(s_axi_awaddr) > 8'h24
		|| $past(s_axi_awaddr[1:0]) != 2'b00) ? 2'b10 : 2'b00))
		else $error("write answer wrong");
	a_bvalid_drop:
	assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response repeated");
	a_read_answer:
	assert property (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid
		|=> s_axi_arready && s_axi_rvalid && (s_axi_rresp == 2'b10)
		== ($past(s_axi_araddr) > 8'h24 || $past(s_axi_araddr[1:0]) != 2'b00))
		else $error("read answer wrong");
	a_unmapped_zero:
	assert property (s_axi_rvalid && s_axi_rresp == 2'b10
		|-> s_axi_rdata == 32'h0000_0000)
		else $error("refused read returned data");
	a_rvalid_drop:
	assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read data repeated");
endmodule // usb_serial_bridge_uart_monitor

bind usb_serial_bridge_uart usb_serial_bridge_uart_monitor
	u_usb_serial_bridge_uart_monitor (.ref_clk, .rst_n, .usb_suspend,
	.usb_resume, .usb_bus_reset, .usb_configured, .sleep_ind, .sleep_ind_n,
	.sleep_ind_oe, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
	.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
	.s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
`default_nettype wire

// [bench/usb_serial_bridge_uart_tb_top.sv]
// Self-checking bench for the bridge core over AXI4-Lite and the serial line.
// Assumes the serial peer model and the register map header.
`include "usb_serial_bridge_map.vh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) \
	begin \
		#1; \
		n_tests++; \
		if ((g) !== (e)) \
		begin \
			error_cnt++; \
			$display("BAD t=%0t got %h exp %h", $time, g, e); \
		end \
	end
module usb_serial_bridge_uart_tb_top;
	logic        ref_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [3:0]  ev = 4'h0;
	logic [3:0]  gpio_in = 4'h0;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0000_0000, rdat;
	logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic        s_axi_arvalid = 0, s_axi_rready = 0;
	logic [1:0]  rrsp;
	logic [9:0]  v;
	int          error_cnt = 0, n_tests = 0;
	wire logic   sleep_ind, sleep_ind_n, sleep_ind_oe, txd, rxd, rts_n, dtr_n;
	wire logic   cts_n, dsr_n, dcd_n, ri_n, s_axi_awready, s_axi_wready;
	wire logic   s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire logic [3:0]  gpio_out, gpio_oe;
	wire logic [1:0]  s_axi_bresp, s_axi_rresp;
	wire logic [31:0] s_axi_rdata;

	always #12.5 ref_clk = ~ref_clk;

	usb_serial_bridge_uart u_usb_serial_bridge_uart (.ref_clk, .rst_n,
		.usb_suspend(ev[0]), .usb_resume(ev[1]), .usb_bus_reset(ev[2]),
		.usb_configured(ev[3]), .sleep_ind, .sleep_ind_n, .sleep_ind_oe,
		.txd, .rxd, .rts_n, .dtr_n, .cts_n, .dsr_n, .dcd_n, .ri_n, .gpio_in,
		.gpio_out, .gpio_oe, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready);
	serial_peer u_serial_peer (.ref_clk, .txd, .rxd, .cts_n, .dsr_n,
		.dcd_n, .ri_n);

	task automatic stop_test;
		$display("tests %0d errors %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic done;
		done = 1'b0;
		@(posedge ref_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!done)
		begin
			@(posedge ref_clk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
			done = s_axi_bvalid;
		end
		s_axi_bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge ref_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge ref_clk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end
		while (!s_axi_rvalid);
		rdat = s_axi_rdata;
		rrsp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		rd(a);
		`CHK(rdat, e)
	endtask

	task automatic pulse(input int i);
		@(posedge ref_clk);
		ev[i] <= 1'b1;
		@(posedge ref_clk);
		ev <= 4'h0;
		repeat (3) @(posedge ref_clk);
	endtask

	task automatic do_reset;
		@(posedge ref_clk);
		rst_n <= 1'b0;
		repeat (5) @(posedge ref_clk);
		`CHK({sleep_ind_oe, sleep_ind, sleep_ind_n}, 3'b011)
		@(posedge ref_clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge ref_clk);
		`CHK({sleep_ind_oe, sleep_ind, sleep_ind_n}, 3'b110)
	endtask

	task automatic t_sleep;
		pulse(3);
		`CHK({sleep_ind, sleep_ind_n}, 2'b01)
		for (int k = 0; k < 3; k++)
		begin
			pulse(0);
			`CHK({sleep_ind, sleep_ind_n}, 2'b10)
			if (k < 2)
				pulse(k + 1);
			else
				wr(`REG_CTRL, 32'h0000_0001);
			repeat (3) @(posedge ref_clk);
			`CHK({sleep_ind, sleep_ind_n}, 2'b01)
		end
	endtask

	task automatic t_regs;
		rc(`REG_LINE, 32'h0000_0003);
		rc(`REG_DIV, 32'h0000_015B);
		wr(`REG_DIV, 32'h0002_08D5);
		rc(`REG_DIV, 32'h0002_08D5);
		wr(`REG_DIV, 32'h0000_002A);
		rc(`REG_DIV, 32'h0002_08D5);
		wr(`REG_DIV, 32'h0000_002B);
		wr(`REG_LINE, 32'h0000_0000);
		rc(`REG_LINE, 32'h0000_0003);
		wr(`REG_LINE, 32'h0000_0007);
		rc(`REG_LINE, 32'h0000_0003);
		wr(`REG_LINE, 32'h0000_0322);
		rc(`REG_LINE, 32'h0000_0322);
	endtask

	task automatic t_data;
		wr(`REG_LINE, 32'h0000_0003);
		u_serial_peer.send(8'h3C, 43);
		rc(`REG_RXDATA, 32'h0000_003C);
		for (int p = 0; p < 5; p++)
		begin
			wr(`REG_LINE, 32'h0000_0003 | (p << 4));
			fork
				wr(`REG_TXDATA, 32'h0000_00A4);
				u_serial_peer.get(v, 43);
			join
			`CHK(v, {1'b1, p == 0 || p == 2 || p == 3, 8'hA4})
			repeat (43) @(posedge ref_clk);
		end
	endtask

	task automatic t_xoff;
		wr(`REG_LINE, 32'h0000_0303);
		u_serial_peer.send(`CHAR_XOFF, 43);
		rd(`REG_STATUS);
		`CHK({rdat[6], rdat[3]}, 2'b10)
		wr(`REG_TXDATA, 32'h0000_0055);
		repeat (100) @(posedge ref_clk);
		`CHK(txd, 1'b1)
		fork
			u_serial_peer.send(`CHAR_XON, 43);
			u_serial_peer.get(v, 43);
		join
		`CHK(v, {2'b11, 8'h55})
	endtask

	task automatic t_misc;
		wr(`REG_GPIO, 32'h0000_00A5);
		gpio_in <= 4'h6;
		`CHK({gpio_oe, gpio_out}, 8'hA5)
		rd(`REG_GPIO);
		`CHK(rdat[11:0], 12'h6A5)
		wr(`REG_CTRL, 32'h0000_000C);
		`CHK({rts_n, dtr_n}, 2'b00)
		rd(8'h28);
		`CHK({rrsp, rdat}, {2'b10, 32'h0000_0000})
		u_serial_peer.modem(4'b0110);
		wr(`REG_LINE, 32'h0000_0103);
		rd(`REG_STATUS);
		`CHK({rdat[10:7], rts_n}, 5'h12)
		u_serial_peer.modem(4'b0111);
		wr(`REG_TXDATA, 32'h0000_005A);
		repeat (100) @(posedge ref_clk);
		`CHK(txd, 1'b1)
		u_serial_peer.modem(4'b0110);
		u_serial_peer.get(v, 43);
		`CHK(v, {2'b11, 8'h5A})
	endtask

	task automatic t_nv;
		wr(`REG_NV_ADDR, 32'h0000_0004);
		rc(`REG_NV_DATA, 32'h0000_0080);
		wr(`REG_NV_ADDR, 32'h0000_0005);
		rc(`REG_NV_DATA, 32'h0000_0032);
		wr(`REG_NV_ADDR, 32'h0000_0008);
		rc(`REG_NV_DATA, 32'h0000_0004);
		wr(`REG_NV_DATA, 32'h0000_0040);
		rc(`REG_NV_DATA, 32'h0000_0004);
		wr(`REG_NV_DATA, 32'h0000_003F);
		rc(`REG_NV_DATA, 32'h0000_003F);
		wr(`REG_NV_CTRL, 32'h0000_0001);
		wr(`REG_NV_DATA, 32'h0000_0010);
		rc(`REG_NV_DATA, 32'h0000_003F);
	endtask

	// The watchdog span is well above the longest serial frame sequence.
	initial
	begin
		#1000000;
		error_cnt++;
		stop_test;
	end

	initial
	begin
		do_reset;
		t_sleep;
		t_regs;
		t_data;
		t_xoff;
		t_misc;
		t_nv;
		do_reset;
		rc(`REG_LINE, 32'h0000_0003);
		stop_test;
	end
endmodule // usb_serial_bridge_uart_tb_top
`default_nettype wire

// [core/usb_serial_bridge_map.vh]
// Register map, field positions, reset values and timing for the bridge.
// Assumes a 40 MHz core clock and an AXI4-Lite master with 32-bit data.
`ifndef USB_SERIAL_BRIDGE_MAP_VH
`define USB_SERIAL_BRIDGE_MAP_VH
`define REG_CTRL      8'h00
`define REG_STATUS    8'h04
`define REG_LINE      8'h08
`define REG_DIV       8'h0C
`define REG_TXDATA    8'h10
`define REG_RXDATA    8'h14
`define REG_GPIO      8'h18
`define REG_NV_ADDR   8'h1C
`define REG_NV_DATA   8'h20
`define REG_NV_CTRL   8'h24
`define CTRL_WAKE     0
`define CTRL_RTS      2
`define CTRL_DTR      3
`define LINE_BITS_LO  0
`define LINE_STOP_LO  2
`define LINE_PAR_LO   4
`define LINE_FLOW_LO  8
`define LINE_RESET    10'h003
`define STOP_ONE      2'd0
`define STOP_ONEHALF  2'd1
`define STOP_TWO      2'd2
`define PAR_NONE      3'd0
`define PAR_ODD       3'd1
`define PAR_EVEN      3'd2
`define PAR_MARK      3'd3
`define PAR_SPACE     3'd4
`define FLOW_NONE     2'd0
`define FLOW_RTSCTS   2'd1
`define FLOW_DTRDSR   2'd2
`define FLOW_XONXOFF  2'd3
`define CHAR_XON      8'h11
`define CHAR_XOFF     8'h13
`define CLK_HZ        40000000
`define BAUD_MIN      300
`define BAUD_MAX      921600
`define BAUD_FAST_EDGE 576000
`define DIV_MIN       (`CLK_HZ / `BAUD_MAX)
`define DIV_MAX       (`CLK_HZ / `BAUD_MIN)
`define DIV_FAST      (`CLK_HZ / `BAUD_FAST_EDGE)
`define DIV_RESET     19'h0_015B
`define NV_SER_LEN    8'h08
`define NV_SER_MAX    8'h3F
`define NV_PRD_LEN    8'h48
`define NV_PRD_MAX    8'h7E
`define NV_LAST       8'hC6
`define NV_ATTR_DEF   8'h80
`define NV_POWER_DEF  8'h32
`define RESP_OKAY     2'b00
`define RESP_SLVERR   2'b10
`endif

// [core/usb_serial_bridge_uart.v]
// Serial bridge core: sleep indicators, serial port, GPIO, descriptor store.
// USB bus events arrive as one-cycle pulses from the USB engine; software
// and the USB command path reach everything over AXI4-Lite.
// Notes on behaviour
// - Move data and execute configuration commands.
// - Sleep when USB suspend is seen.
// - Sleep asserts both indicator outputs.
// - Indicators held asserted until configuration completes.
// - Resume, bus reset or device reset wake.
// - Waking deasserts both indicator outputs.
// - Indicators float high during device reset.
// - True indicator high, complement low asleep.
// - Data lines plus three flow-control methods.
// - Modem lines active low, RTS/DTR out.
// - Five to eight bits; 1.5 stop only five.
// - None, even, odd, mark, space parity.
// - Rate generator covers 300 to 921600.
// - Top rate only with seven/eight bits.
// - Four GPIO pins, each in or out.
// - Store holds identity, power, serial, product.
// - Unprogrammed store reports default descriptors.
// - Serial 63 chars, product 126 chars maximum.
// - Store written over the host connection.
// - Lock refuses further descriptor changes.
`include "usb_serial_bridge_map.vh"
`timescale 1ns/1ps
`default_nettype none
module usb_serial_bridge_uart #(
	parameter [15:0] VID_DEFAULT = 16'h1234, // arbitrary value
	parameter [15:0] PID_DEFAULT = 16'h5678, // arbitrary value
	parameter [15:0] REL_DEFAULT = 16'h0001  // arbitrary value
) (
	input  wire        ref_clk,
	input  wire        rst_n,
	input  wire        usb_suspend,
	input  wire        usb_resume,
	input  wire        usb_bus_reset,
	input  wire        usb_configured,
	output reg         sleep_ind,
	output reg         sleep_ind_n,
	output reg         sleep_ind_oe,
	output reg         txd,
	input  wire        rxd,
	output reg         rts_n,
	output reg         dtr_n,
	input  wire        cts_n,
	input  wire        dsr_n,
	input  wire        dcd_n,
	input  wire        ri_n,
	input  wire [3:0]  gpio_in,
	output reg  [3:0]  gpio_out,
	output reg  [3:0]  gpio_oe,
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready
);
	localparam TX_IDLE = 3'd0, TX_START = 3'd1, TX_DATA = 3'd2;
	localparam TX_PAR = 3'd3, TX_STOP = 3'd4;
	localparam RX_IDLE = 3'd0, RX_START = 3'd1, RX_DATA = 3'd2;
	localparam RX_PAR = 3'd3, RX_STOP = 3'd4;
	// The divisor limits are worked out as integers and cut to width here.
	localparam integer DIV_MIN_I = `DIV_MIN;
	localparam integer DIV_MAX_I = `DIV_MAX;
	localparam integer DIV_FAST_I = `DIV_FAST;
	localparam [18:0] DIV_MIN = DIV_MIN_I[18:0];
	localparam [18:0] DIV_MAX = DIV_MAX_I[18:0];
	localparam [18:0] DIV_FAST = DIV_FAST_I[18:0];

	reg         asleep;
	reg         configured;
	reg  [3:0]  ctrl;
	reg  [9:0]  line;
	reg  [18:0] div;
	reg  [7:0]  gpio_dir;
	reg  [7:0]  nv_addr;
	reg         nv_prog;
	reg         nv_lock;
	reg  [7:0]  nv_mem [0:255];
	reg  [7:0]  tx_hold;
	reg         tx_pend;
	reg         tx_par_bit;
	reg  [2:0]  tx_state;
	reg  [18:0] tx_cnt;
	reg  [2:0]  tx_bit;
	reg  [7:0]  tx_shift;
	reg         xoff;
	reg  [2:0]  rx_state;
	reg  [18:0] rx_cnt;
	reg  [2:0]  rx_bit;
	reg  [7:0]  rx_shift;
	reg  [7:0]  rx_data;
	reg         rx_valid;
	reg         rx_overrun;
	reg         rx_err;
	reg  [31:0] rd_mux;
	reg  [1:0]  rd_resp;

	wire [2:0]  last_bit = {1'b1, line[1:0]};
	wire [1:0]  stop_sel = line[`LINE_STOP_LO+1:`LINE_STOP_LO];
	wire [2:0]  par_sel = line[`LINE_PAR_LO+2:`LINE_PAR_LO];
	wire [1:0]  flow = line[`LINE_FLOW_LO+1:`LINE_FLOW_LO];
	wire [7:0]  bit_mask = 8'hFF >> (3'd3 - line[1:0]);
	wire [18:0] half_div = {1'b0, div[18:1]};
	wire [18:0] stop_len = (stop_sel == `STOP_ONE) ? div :
		(stop_sel == `STOP_ONEHALF) ? div + half_div : {div[17:0], 1'b0};
	wire        wr_en = s_axi_awvalid & s_axi_wvalid & ~s_axi_awready &
		~s_axi_bvalid;
	wire        wr_ok = wr_en & s_axi_wstrb[0];
	wire        rd_en = s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
	wire [7:0]  wb = s_axi_wdata[7:0];
	wire        rx_take = rd_en & (s_axi_araddr == `REG_RXDATA);
	wire        wake = usb_resume | usb_bus_reset |
		(wr_ok & (s_axi_awaddr == `REG_CTRL) & wb[`CTRL_WAKE]);
	// legal frame shapes
	// Illegal frame shapes: 1.5 stop bits need five data bits.
	wire [1:0]  new_bits = s_axi_wdata[1:0];
	wire        new_stop_ok = (s_axi_wdata[3:2] != 2'd3) &&
		(s_axi_wdata[3:2] != `STOP_ONEHALF || new_bits == 2'd0);
	wire        new_line_ok = new_stop_ok && (s_axi_wdata[6:4] <= 3'd4) &&
		(div >= DIV_FAST || new_bits[1]);
	wire [18:0] new_div = s_axi_wdata[18:0];
	wire        new_div_ok = (new_div >= DIV_MIN) && (new_div <= DIV_MAX) &&
		(new_div >= DIV_FAST || line[1]);
	wire        nv_ok = ~nv_lock && nv_addr <= `NV_LAST &&
		!(nv_addr == `NV_SER_LEN && wb > `NV_SER_MAX) &&
		!(nv_addr == `NV_PRD_LEN && wb > `NV_PRD_MAX);
	wire [7:0]  tx_masked = tx_hold & bit_mask;
	wire [7:0]  rx_masked = rx_shift >> (3'd3 - line[1:0]);
	wire        tx_par = (par_sel == `PAR_ODD) ? ~^tx_masked :
		(par_sel == `PAR_EVEN) ? ^tx_masked : (par_sel == `PAR_MARK);
	wire        rx_par_exp = (par_sel == `PAR_ODD) ? ~^rx_masked :
		(par_sel == `PAR_EVEN) ? ^rx_masked : (par_sel == `PAR_MARK);
	wire        tx_allowed = !(flow == `FLOW_RTSCTS && cts_n) &&
		!(flow == `FLOW_DTRDSR && dsr_n) &&
		!(flow == `FLOW_XONXOFF && xoff);

	// default descriptor data
	// Defaults stand until the first accepted store write.
	function [7:0] nv_default;
		input [7:0] a;
		begin
			case (a)
			8'h00: nv_default = VID_DEFAULT[7:0];
			8'h01: nv_default = VID_DEFAULT[15:8];
			8'h02: nv_default = PID_DEFAULT[7:0];
			8'h03: nv_default = PID_DEFAULT[15:8];
			8'h04: nv_default = `NV_ATTR_DEF;
			8'h05: nv_default = `NV_POWER_DEF;
			8'h06: nv_default = REL_DEFAULT[7:0];
			8'h07: nv_default = REL_DEFAULT[15:8];
			8'h08: nv_default = 8'h04;
			8'h09, 8'h0A, 8'h0B: nv_default = 8'h30;
			8'h0C: nv_default = 8'h31;
			default: nv_default = 8'h00;
			endcase
		end
	endfunction

	// wake events leave sleep
	// A wake event in the same cycle as suspend wins, so we never sleep
	// straight through a resume.
	always @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			asleep <= 1'b0;
			configured <= 1'b0;
		end
		else
		begin
			if (wake)
				asleep <= 1'b0;
			else if (usb_suspend)
				asleep <= 1'b1;
			if (usb_configured)
				configured <= 1'b1;
		end
	end

	// float during reset
	// The indicator drivers stay off through reset so the pins float high.
	always @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sleep_ind <= 1'b1;
			sleep_ind_n <= 1'b1;
			sleep_ind_oe <= 1'b0;
		end
		else
		begin
			sleep_ind_oe <= 1'b1;
			sleep_ind <= asleep | ~configured;
			sleep_ind_n <= ~(asleep | ~configured);
		end
	end

	// host store writes
	// Store writes are taken from the bus; the array itself has no reset.
	always @(posedge ref_clk)
	begin
		if (wr_ok && s_axi_awaddr == `REG_NV_DATA && nv_ok)
			nv_mem[nv_addr] <= wb;
	end

	always @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ctrl <= 4'h0;
			line <= `LINE_RESET;
			div <= `DIV_RESET;
			gpio_dir <= 8'h00;
			nv_addr <= 8'h00;
			nv_prog <= 1'b0;
			nv_lock <= 1'b0;
		end
		else if (wr_ok)
		begin
			case (s_axi_awaddr)
			`REG_CTRL: ctrl <= {wb[3:2], 2'b00};
			`REG_LINE:
				if (new_line_ok)
					line <= s_axi_wdata[9:0];
			`REG_DIV:
				if (new_div_ok)
					div <= new_div;
			`REG_GPIO: gpio_dir <= wb;
			`REG_NV_ADDR: nv_addr <= wb;
			`REG_NV_DATA:
				if (nv_ok)
					nv_prog <= 1'b1;
			`REG_NV_CTRL:
				if (wb[0])
					nv_lock <= 1'b1;
			default: nv_addr <= nv_addr;
			endcase
		end
	end

	// Pin outputs mirror the registered control bits one edge later; RTS/DTR follow rx_valid under their flow mode.
	always @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			gpio_out <= 4'h0;
			gpio_oe <= 4'h0;
			rts_n <= 1'b1;
			dtr_n <= 1'b1;
		end
		else
		begin
			gpio_out <= gpio_dir[3:0];
			gpio_oe <= gpio_dir[7:4];
			rts_n <= (flow == `FLOW_RTSCTS) ? rx_valid : ~ctrl[`CTRL_RTS];
			dtr_n <= (flow == `FLOW_DTRDSR) ? rx_valid : ~ctrl[`CTRL_DTR];
		end
	end

	// transmit data line
	// Transmitter: start, data LSB first, optional parity, stop.
	// Parity is latched with the byte, so a byte written mid-frame cannot
	// change the parity of the frame already on the line.
	always @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tx_state <= TX_IDLE;
			tx_cnt <= 19'h0_0000;
			tx_bit <= 3'd0;
			tx_shift <= 8'h00;
			tx_pend <= 1'b0;
			tx_hold <= 8'h00;
			tx_par_bit <= 1'b0;
			txd <= 1'b1;
		end
		else
		begin
			if (wr_ok && s_axi_awaddr == `REG_TXDATA && !tx_pend)
			begin
				tx_hold <= wb;
				tx_pend <= 1'b1;
			end
			if (tx_cnt != 19'h0_0000)
				tx_cnt <= tx_cnt - 19'h0_0001;
			case (tx_state)
			TX_IDLE:
			begin
				txd <= 1'b1;
				if (tx_pend && tx_allowed)
				begin
					tx_shift <= tx_masked;
					tx_par_bit <= tx_par;
					tx_pend <= 1'b0;
					txd <= 1'b0;
					tx_cnt <= div - 19'h0_0001;
					tx_state <= TX_START;
				end
			end
			TX_START:
				if (tx_cnt == 19'h0_0000)
				begin
					txd <= tx_shift[0];
					tx_bit <= 3'd0;
					tx_cnt <= div - 19'h0_0001;
					tx_state <= TX_DATA;
				end
			TX_DATA:
				if (tx_cnt == 19'h0_0000)
				begin
					tx_cnt <= div - 19'h0_0001;
					tx_shift <= {1'b0, tx_shift[7:1]};
					tx_bit <= tx_bit + 3'd1;
					if (tx_bit != last_bit)
						txd <= tx_shift[1];
					else if (par_sel != `PAR_NONE)
					begin
						txd <= tx_par_bit;
						tx_state <= TX_PAR;
					end
					else
					begin
						txd <= 1'b1;
						tx_cnt <= stop_len - 19'h0_0001;
						tx_state <= TX_STOP;
					end
				end
			TX_PAR:
				if (tx_cnt == 19'h0_0000)
				begin
					txd <= 1'b1;
					tx_cnt <= stop_len - 19'h0_0001;
					tx_state <= TX_STOP;
				end
			TX_STOP:
				if (tx_cnt == 19'h0_0000)
					tx_state <= TX_IDLE;
			default: tx_state <= TX_IDLE;
			endcase
		end
	end

	// Receiver samples each bit at its middle.
	always @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rx_state <= RX_IDLE;
			rx_cnt <= 19'h0_0000;
			rx_bit <= 3'd0;
			rx_shift <= 8'h00;
			rx_data <= 8'h00;
			rx_valid <= 1'b0;
			rx_overrun <= 1'b0;
			rx_err <= 1'b0;
			xoff <= 1'b0;
		end
		else
		begin
			// A frame landing on the reading cycle still sets the flag.
			if (rx_take)
			begin
				rx_valid <= 1'b0;
				rx_overrun <= 1'b0;
				rx_err <= 1'b0;
			end
			if (flow != `FLOW_XONXOFF)
				xoff <= 1'b0;
			if (rx_cnt != 19'h0_0000)
				rx_cnt <= rx_cnt - 19'h0_0001;
			case (rx_state)
			RX_IDLE:
				if (!rxd)
				begin
					rx_cnt <= half_div;
					rx_state <= RX_START;
				end
			RX_START:
				if (rx_cnt == 19'h0_0000)
				begin
					rx_cnt <= div - 19'h0_0001;
					rx_bit <= 3'd0;
					rx_state <= rxd ? RX_IDLE : RX_DATA;
				end
			RX_DATA:
				if (rx_cnt == 19'h0_0000)
				begin
					rx_cnt <= div - 19'h0_0001;
					rx_shift <= {rxd, rx_shift[7:1]};
					rx_bit <= rx_bit + 3'd1;
					if (rx_bit == last_bit)
						rx_state <= (par_sel != `PAR_NONE) ? RX_PAR : RX_STOP;
				end
			RX_PAR:
				if (rx_cnt == 19'h0_0000)
				begin
					rx_cnt <= div - 19'h0_0001;
					if (rxd != rx_par_exp)
						rx_err <= 1'b1;
					rx_state <= RX_STOP;
				end
			RX_STOP:
				if (rx_cnt == 19'h0_0000)
				begin
					rx_state <= RX_IDLE;
					if (!rxd)
						rx_err <= 1'b1;
					if (flow == `FLOW_XONXOFF && rx_masked == `CHAR_XOFF)
						xoff <= 1'b1;
					else if (flow == `FLOW_XONXOFF && rx_masked == `CHAR_XON)
						xoff <= 1'b0;
					else
					begin
						rx_data <= rx_masked;
						rx_valid <= 1'b1;
						if (rx_valid && !rx_take)
							rx_overrun <= 1'b1;
					end
				end
			default: rx_state <= RX_IDLE;
			endcase
		end
	end

	always @*
	begin
		rd_resp = `RESP_OKAY;
		case (s_axi_araddr)
		`REG_CTRL: rd_mux = {28'h000_0000, ctrl};
		`REG_STATUS: rd_mux = {19'h0_0000, nv_lock, nv_prog, ~ri_n, ~dcd_n,
			~dsr_n, ~cts_n, xoff, rx_err, rx_overrun, rx_valid,
			tx_pend | (tx_state != TX_IDLE), configured, asleep};
		`REG_LINE: rd_mux = {22'h00_0000, line};
		`REG_DIV: rd_mux = {13'h0000, div};
		`REG_RXDATA: rd_mux = {24'h00_0000, rx_data};
		`REG_GPIO: rd_mux = {20'h0_0000, gpio_in, gpio_dir};
		`REG_NV_ADDR: rd_mux = {24'h00_0000, nv_addr};
		`REG_NV_DATA: rd_mux = {24'h00_0000,
			nv_prog ? nv_mem[nv_addr] : nv_default(nv_addr)};
		`REG_NV_CTRL: rd_mux = {31'h0000_0000, nv_lock};
		`REG_TXDATA: rd_mux = 32'h0000_0000;
		default:
		begin
			rd_mux = 32'h0000_0000;
			rd_resp = `RESP_SLVERR;
		end
		endcase
	end

	// One write and one read in flight; each is answered the next edge.
	always @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= `RESP_OKAY;
			s_axi_rdata <= 32'h0000_0000;
		end
		else
		begin
			s_axi_awready <= wr_en;
			s_axi_wready <= wr_en;
			s_axi_arready <= rd_en;
			if (wr_en)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (s_axi_awaddr > `REG_NV_CTRL ||
					s_axi_awaddr[1:0] != 2'b00) ? `RESP_SLVERR : `RESP_OKAY;
			end
			else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
			if (rd_en)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_mux;
				s_axi_rresp <= rd_resp;
			end
			else if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end
endmodule // usb_serial_bridge_uart
`default_nettype wire
